// File: logic/bor_pkg.sv
package bor_pkg;

    // ----------------------------------------------------------------
    // register byte addresses (axi4-lite, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_CAUSE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_STATE = 8'h10;

    // ----------------------------------------------------------------
    // level codes
    // ----------------------------------------------------------------
    localparam logic [7:0] LVL_1V70 = 8'h66;
    localparam logic [7:0] LVL_1V90 = 8'h55;
    localparam logic [7:0] LVL_2V55 = 8'h33;
    localparam logic [7:0] LVL_3V15 = 8'h99;
    localparam logic [7:0] LVL_3V80 = 8'haa;
    localparam logic [7:0] LVL_OFF = 8'hf0;
    localparam logic [7:0] LEVEL_RESET = 8'h66;

    // threshold select encoding sent to the comparator
    localparam logic [2:0] THR_1V70 = 3'h0;
    localparam logic [2:0] THR_1V90 = 3'h1;
    localparam logic [2:0] THR_2V55 = 3'h2;
    localparam logic [2:0] THR_3V15 = 3'h3;
    localparam logic [2:0] THR_3V80 = 3'h4;

    // ----------------------------------------------------------------
    // cause register bit positions
    // ----------------------------------------------------------------
    localparam int CAUSE_WDG = 0;
    localparam int CAUSE_LVL = 1;
    localparam int CAUSE_BOR = 2;
    localparam int CAUSE_RST = 3;

    // interrupt status bit positions
    localparam int IRQ_BOR = 0;
    localparam int IRQ_LVL = 1;
    localparam int IRQ_WDG = 2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int QUALIFY_TIME_US = 120;
    localparam int QUALIFY_CYCLES = QUALIFY_TIME_US * CLK_MHZ;
    localparam int FAULT_DELAY_US = 50;
    localparam int FAULT_DELAY_CYCLES = FAULT_DELAY_US * CLK_MHZ;
    localparam int RESET_PULSE_CYCLES = 4;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // power modes
    typedef enum logic [1:0]
    {
        PM_FAST = 2'b00,
        PM_SLOW = 2'b01,
        PM_IDLE = 2'b10,
        PM_SLEEP = 2'b11
    } bor_mode_e;

endpackage

// File: logic/bor_reset_logic.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - code 66h gives 1.7V, 55h gives 1.9V
// - codes 33h, 99h, aah give 2.55/3.15/3.8V
// - code f0h disables brownout reset
// - low supply must outlast qualify time
// - qualified brownout sets brownout flag
// - brownout reset keeps level register contents
// - undefined level code: fault flag, delayed reset
// - code fault reset restores level to 66h
// - brownout off in idle or sleep
// - cause bits 3..0 rst,bor,lvl,wdg; upper zero
// - flags set by hardware, cleared by writing zero
// - run-mode timeout: device reset, timeout flag set
// - sleep timeout: clear pc and sp only
// - status flags per reset kind
// - power-on clears watchdog, then counting starts
// - power-on: irqs off, timers off, inputs, pc zero
module bor_reset_logic
    import bor_pkg::*;
#(
    parameter int QUALIFY_CNT = QUALIFY_CYCLES,
    parameter int FAULT_CNT = FAULT_DELAY_CYCLES
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog comparator
    input wire logic supply_low,
    output logic [2:0] bor_threshold,
    output logic bor_enable,
    // system events
    input wire logic power_on,
    input wire logic [1:0] power_mode,
    input wire logic wdg_timeout,
    input wire logic wdg_code_fault,
    input wire logic rst_code_fault,
    // reset outputs
    output logic full_reset,
    output logic pc_sp_clear,
    output logic wdg_clear,
    output logic periph_init,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic irq
);

    // ----------------------------------------------------------------
    // level code decode
    // ----------------------------------------------------------------
    function automatic logic code_valid(input logic [7:0] c);
        code_valid = (c == LVL_1V70) || (c == LVL_1V90) || (c == LVL_2V55) ||
                     (c == LVL_3V15) || (c == LVL_3V80) || (c == LVL_OFF);
    endfunction

    logic [7:0] level_r; // brownout_level_register
    logic [3:0] cause_r; // reset_cause_register
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic timeout_r;
    logic powerdown_r;

    // supply_low comes from the analog side: three-stage synchroniser
    logic [2:0] low_sync_r;
    wire low_q = low_sync_r[1] & low_sync_r[2];
    wire high_q = ~low_sync_r[1] & ~low_sync_r[2];
    logic low_stable_r;

    wire sleepy = (power_mode == PM_IDLE) || (power_mode == PM_SLEEP);
    wire lvl_ok = code_valid(level_r);
    wire bor_on = (level_r != LVL_OFF) && lvl_ok && !sleepy;

    // threshold encoding; off and undefined codes fall back to the lowest level
    wire [2:0] thr_sel = (level_r == LVL_1V90) ? THR_1V90 :
                         (level_r == LVL_2V55) ? THR_2V55 :
                         (level_r == LVL_3V15) ? THR_3V15 :
                         (level_r == LVL_3V80) ? THR_3V80 : THR_1V70;

    // ----------------------------------------------------------------
    // qualification and fault delay counters
    // ----------------------------------------------------------------
    logic [31:0] qual_cnt_r;
    logic [31:0] fault_cnt_r;
    logic [2:0] pulse_cnt_r;
    // qualified brownout: low held beyond the qualify count
    wire bor_event = bor_on && low_stable_r && (qual_cnt_r == 32'(QUALIFY_CNT));
    wire lvl_event = !lvl_ok && (fault_cnt_r == 32'(FAULT_CNT));
    wire wdg_run = wdg_timeout && !sleepy;
    wire wdg_slp = wdg_timeout && sleepy;
    wire any_full = bor_event | lvl_event | wdg_run | power_on;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_sync_r <= 3'h0;
            low_stable_r <= 1'b0;
        end
        else if (clk_en)
        begin
            low_sync_r <= {low_sync_r[1:0], supply_low};
            // a change counts only once stages two and three agree
            if (low_q)
                low_stable_r <= 1'b1;
            else if (high_q)
                low_stable_r <= 1'b0;
        end
    end

    // short low pulses reset the count, so they never reach the limit;
    // the fault delay runs only while the level code is undefined
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            qual_cnt_r <= 32'h0;
            fault_cnt_r <= 32'h0;
        end
        else if (clk_en)
        begin
            if (!bor_on || !low_stable_r || bor_event)
                qual_cnt_r <= 32'h0;
            else
                qual_cnt_r <= qual_cnt_r + 32'h1;
            if (lvl_ok || lvl_event)
                fault_cnt_r <= 32'h0;
            else
                fault_cnt_r <= fault_cnt_r + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_r || aw_take;
    wire w_have = w_held_r || w_take;
    wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid;
    wire wr_lane0 = wr_fire && wr_strb[0];
    wire wr_level = wr_lane0 && (wr_addr == ADDR_LEVEL);
    wire wr_cause = wr_lane0 && (wr_addr == ADDR_CAUSE);
    wire wr_istat = wr_lane0 && (wr_addr == ADDR_IRQ_STATUS);
    wire wr_imask = wr_lane0 && (wr_addr == ADDR_IRQ_MASK);
    wire wr_known = (wr_addr == ADDR_LEVEL) || (wr_addr == ADDR_CAUSE) ||
                    (wr_addr == ADDR_IRQ_STATUS) || (wr_addr == ADDR_IRQ_MASK) ||
                    (wr_addr == ADDR_STATE);

    // channel accept: one write in flight, each channel held until pair done
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (aw_take)
                aw_addr_r <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= aw_have && !wr_fire;
            w_held_r <= w_have && !wr_fire;
            s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
            s_axi_wready <= !w_have && !s_axi_bvalid && !s_axi_wready;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read side
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_known = (s_axi_araddr == ADDR_LEVEL) || (s_axi_araddr == ADDR_CAUSE) ||
                    (s_axi_araddr == ADDR_IRQ_STATUS) || (s_axi_araddr == ADDR_IRQ_MASK) ||
                    (s_axi_araddr == ADDR_STATE);
    wire [31:0] rd_mux = (s_axi_araddr == ADDR_LEVEL) ? {24'h0, level_r} :
                         (s_axi_araddr == ADDR_CAUSE) ? {28'h0, cause_r} :
                         (s_axi_araddr == ADDR_IRQ_STATUS) ? {29'h0, irq_stat_r} :
                         (s_axi_araddr == ADDR_IRQ_MASK) ? {29'h0, irq_mask_r} :
                         (s_axi_araddr == ADDR_STATE) ? {26'h0, power_mode, bor_on, lvl_ok, timeout_r, powerdown_r} :
                         32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rd_fire;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // level register and cause flags
    // ----------------------------------------------------------------
    // brownout reset leaves the level untouched; code fault restores it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_r <= LEVEL_RESET;
        else if (clk_en)
        begin
            if (lvl_event || power_on)
                level_r <= LEVEL_RESET;
            else if (wr_level)
                level_r <= wr_data[7:0];
        end
    end

    // software write of zero clears; any set in the same cycle wins
    wire [3:0] cause_set = {rst_code_fault, bor_event, lvl_event, wdg_code_fault};
    wire [3:0] cause_keep = wr_cause ? (cause_r & wr_data[3:0]) : cause_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cause_r <= 4'h0;
        else if (clk_en)
            cause_r <= cause_keep | cause_set;
    end

    // ----------------------------------------------------------------
    // interrupt status and mask (write one to clear)
    // ----------------------------------------------------------------
    wire [2:0] irq_set = {wdg_timeout, lvl_event, bor_event};
    wire [2:0] irq_keep = wr_istat ? (irq_stat_r & ~wr_data[2:0]) : irq_stat_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_r <= 3'h0;
            irq_mask_r <= 3'h0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_stat_r <= irq_keep | irq_set;
            if (wr_imask)
                irq_mask_r <= wr_data[2:0];
            irq <= |((irq_keep | irq_set) & irq_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // status flags and reset pulses
    // ----------------------------------------------------------------
    // power-on clears both; brownout leaves both; timeouts per mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timeout_r <= 1'b0;
            powerdown_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (power_on)
            begin
                timeout_r <= 1'b0;
                powerdown_r <= 1'b0;
            end
            else if (wdg_slp)
            begin
                timeout_r <= 1'b1;
                powerdown_r <= 1'b1;
            end
            else if (wdg_run)
                timeout_r <= 1'b1;
        end
    end

    // full reset stretched for a few cycles; pc/sp clear for sleep timeout
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pulse_cnt_r <= 3'h0;
            full_reset <= 1'b0;
            pc_sp_clear <= 1'b0;
            wdg_clear <= 1'b0;
            periph_init <= 1'b0;
            bor_threshold <= THR_1V70;
            bor_enable <= 1'b0;
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (any_full)
                pulse_cnt_r <= 3'(RESET_PULSE_CYCLES);
            else if (pulse_cnt_r != 3'h0)
                pulse_cnt_r <= pulse_cnt_r - 3'h1;
            full_reset <= any_full || (pulse_cnt_r > 3'h1);
            pc_sp_clear <= wdg_slp;
            wdg_clear <= power_on;
            periph_init <= power_on;
            // comparator controls and flags, registered so every output is a flop
            bor_threshold <= thr_sel;
            bor_enable <= bor_on;
            timeout_flag <= timeout_r;
            powerdown_flag <= powerdown_r;
        end
    end

endmodule

// File: dv/bor_reset_logic_monitor.sv
`timescale 1ns/10ps
module bor_reset_logic_monitor
    import bor_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // system events
    input wire logic [1:0] power_mode,
    input wire logic power_on,
    input wire logic wdg_timeout,
    // reset outputs
    input wire logic bor_enable,
    input wire logic full_reset,
    input wire logic pc_sp_clear,
    input wire logic wdg_clear,
    input wire logic periph_init,
    input wire logic timeout_flag,
    input wire logic powerdown_flag
);
    // ----------------------------------------------------------------
    // one clock domain, checks muted while reset is held
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // timeout while idle or sleep, and while running
    sequence s_sleep_to; wdg_timeout && power_mode[1]; endsequence
    sequence s_run_to; wdg_timeout && !power_mode[1]; endsequence
    // two cycles in a low power mode, so the registered enable has caught up
    sequence s_low_mode; power_mode[1] ##1 power_mode[1]; endsequence

    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_low_off; s_low_mode |-> !bor_enable; endproperty
    property p_run_to; s_run_to |-> ##[1:2] (full_reset && timeout_flag); endproperty
    property p_run_pd; s_run_to |=> ##1 (powerdown_flag == $past(powerdown_flag, 2)); endproperty
    property p_sleep_clr; s_sleep_to |-> ##[1:2] (pc_sp_clear && !full_reset); endproperty
    property p_sleep_flags; s_sleep_to |-> ##[1:3] (timeout_flag && powerdown_flag); endproperty
    property p_por_flags; power_on |-> ##[1:3] (!timeout_flag && !powerdown_flag); endproperty
    property p_por_wdg; power_on |-> ##[1:3] wdg_clear; endproperty
    property p_por_init; power_on |-> ##[1:3] periph_init; endproperty

    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    a_low_off: assert property (p_low_off) else $error("brownout armed in low power mode");
    a_run_to: assert property (p_run_to) else $error("run timeout without reset");
    a_run_pd: assert property (p_run_pd) else $error("run timeout moved powerdown");
    a_sleep_clr: assert property (p_sleep_clr) else $error("sleep timeout clear wrong");
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep timeout flags wrong");
    a_por_flags: assert property (p_por_flags) else $error("power on flags wrong");
    a_por_wdg: assert property (p_por_wdg) else $error("power on watchdog clear missing");
    a_por_init: assert property (p_por_init) else $error("power on init missing");
endmodule

// File: dv/tb_bor_reset_logic.sv
`timescale 1ns/10ps
module tb_bor_reset_logic
    import bor_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, supply_low = 1'b0;
    logic power_on = 1'b0, wdg_timeout = 1'b0, wdg_code_fault = 1'b0, rst_code_fault = 1'b0;
    logic [1:0] power_mode = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bor_enable, irq;
    logic full_reset, pc_sp_clear, wdg_clear, periph_init, timeout_flag, powerdown_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic [2:0] bor_threshold;
    logic [31:0] s_axi_rdata, rd;
    int fails = 0, check_count = 0, cyc = 0;
    int cnt[4] = '{0, 0, 0, 0};
    int base[4];
    // rows: level code, threshold, armed
    logic [7:0] codes[6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
    logic [2:0] thr[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic en[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    // short counts keep the qualify and fault waits brief
    bor_reset_logic #(.QUALIFY_CNT(8), .FAULT_CNT(6)) i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .supply_low(supply_low), .bor_threshold(bor_threshold),
        .bor_enable(bor_enable), .power_on(power_on), .power_mode(power_mode), .wdg_timeout(wdg_timeout),
        .wdg_code_fault(wdg_code_fault), .rst_code_fault(rst_code_fault), .full_reset(full_reset),
        .pc_sp_clear(pc_sp_clear), .wdg_clear(wdg_clear), .periph_init(periph_init),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));

    initial forever #5 aclk = ~aclk;

    // pulse counters, so a test can see a one-cycle output it did not sample at the right edge
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (full_reset === 1'b1) cnt[0] <= cnt[0] + 1;
        if (pc_sp_clear === 1'b1) cnt[1] <= cnt[1] + 1;
        if (wdg_clear === 1'b1) cnt[2] <= cnt[2] + 1;
        if (periph_init === 1'b1) cnt[3] <= cnt[3] + 1;
        // hang guard, the whole run needs about 600 cycles
        if (cyc == 20000)
        begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // did output k pulse since the last snapshot
    task seen(input int k, input logic e);
        chk({31'h0, cnt[k] != base[k]}, {31'h0, e});
    endtask

    // write: address and data offered together, each dropped when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (!ad && s_axi_awready === 1'b1)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready === 1'b1)
            begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // late bready makes the response stand for a cycle
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one-cycle event pulse: power_on, wdg_timeout, wdg_code_fault, rst_code_fault
    task ev(input logic [3:0] e);
        base = cnt;
        @(posedge aclk);
        {power_on, wdg_timeout, wdg_code_fault, rst_code_fault} <= e;
        @(posedge aclk);
        {power_on, wdg_timeout, wdg_code_fault, rst_code_fault} <= 4'h0;
        repeat (8) @(posedge aclk);
    endtask

    // supply low for n cycles, then settle past the reset stretch
    task low(input int n);
        base = cnt;
        @(posedge aclk);
        supply_low <= 1'b1;
        repeat (n) @(posedge aclk);
        supply_low <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(ADDR_LEVEL);
        chk(rd, 32'h66);
        rdr(ADDR_CAUSE);
        chk(rd & 32'hfb, 32'h0);
        rdr(8'h20);
        chk({rd[29:0], rr}, {30'h0, RESP_SLVERR});
        wr(8'h20, 32'h0);
        chk({30'h0, br}, {30'h0, RESP_SLVERR});
        // every level code, then a long low supply under it
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_LEVEL, {24'h0, codes[i]});
            chk({30'h0, br}, {30'h0, RESP_OKAY});
            repeat (2) @(posedge aclk);
            chk({31'h0, bor_enable}, {31'h0, en[i]});
            if (en[i]) chk({29'h0, bor_threshold}, {29'h0, thr[i]});
            low(20);
            seen(0, en[i]);
            rdr(ADDR_LEVEL);
            chk(rd, {24'h0, codes[i]});
        end
        rdr(ADDR_CAUSE);
        chk(rd & 32'h4, 32'h4);
        wr(ADDR_CAUSE, 32'hfb);
        rdr(ADDR_CAUSE);
        chk(rd & 32'h4, 32'h0);
        // short dip is ignored, idle disarms
        wr(ADDR_LEVEL, 32'h66);
        low(4);
        seen(0, 1'b0);
        power_mode <= PM_IDLE;
        low(20);
        seen(0, 1'b0);
        power_mode <= PM_FAST;
        // fault event flags
        wr(ADDR_CAUSE, 32'h0);
        ev(4'h2);
        ev(4'h1);
        rdr(ADDR_CAUSE);
        chk(rd, 32'h9);
        // undefined level code
        wr(ADDR_LEVEL, 32'h12);
        base = cnt;
        repeat (30) @(posedge aclk);
        seen(0, 1'b1);
        rdr(ADDR_CAUSE);
        chk(rd & 32'h2, 32'h2);
        rdr(ADDR_LEVEL);
        chk(rd, 32'h66);
        // run timeout, then sleep timeout with the interrupt unmasked and masked
        ev(4'h4);
        seen(0, 1'b1);
        chk({30'h0, timeout_flag, powerdown_flag}, 32'h2);
        wr(ADDR_IRQ_MASK, 32'h4);
        wr(ADDR_IRQ_STATUS, 32'h7);
        chk({31'h0, irq}, 32'h0);
        power_mode <= PM_SLEEP;
        ev(4'h4);
        seen(1, 1'b1);
        seen(0, 1'b0);
        chk({30'h0, timeout_flag, powerdown_flag, irq}, 32'h7);
        wr(ADDR_IRQ_STATUS, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
        ev(4'h4);
        chk({31'h0, irq}, 32'h0);
        power_mode <= PM_SLOW;
        ev(4'h4);
        chk({30'h0, timeout_flag, powerdown_flag}, 32'h3);
        // power on clears both flags and restarts the watchdog
        ev(4'h8);
        chk({30'h0, timeout_flag, powerdown_flag}, 32'h0);
        seen(2, 1'b1);
        seen(3, 1'b1);
        report_and_stop();
    end
endmodule

bind bor_reset_logic bor_reset_logic_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .power_mode(power_mode), .power_on(power_on), .wdg_timeout(wdg_timeout),
    .bor_enable(bor_enable), .full_reset(full_reset), .pc_sp_clear(pc_sp_clear), .wdg_clear(wdg_clear),
    .periph_init(periph_init), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
